/* File: design/ets_source_select.sv */
// Encoder and home timing source selector with count and feedback position
// Contract
// - Source 0 none, 1 driver, 2 external
// - Count follows selected encoder A/B phases
// - Count scaled to user units as feedback
// - Source 0 holds count at zero
// - Commanded position change may move feedback
// - Zero pulse, not A/B, drives timing
// - Timing setting 1 routes single-ended input
// - Timing 0: diff input or external zero
// - Both zero: home seek that uses timing (HOME_USES_TIMING) raises alarm
// - Changes apply after save and reset
// - Immediate writes allowed; sequence writes refused
`timescale 1ns/1ns
module ets_source_select (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic DRV_PHASE_A,
   input wire logic DRV_PHASE_B,
   input wire logic EXT_PHASE_A,
   input wire logic EXT_PHASE_B,
   input wire logic DRV_DIFF_TIMING_IN,
   input wire logic EXT_ZERO_PULSE,
   input wire logic SINGLE_TIMING_IN,
   input wire logic SET_WR,
   input wire logic SET_FROM_SEQ,
   input wire ets_pkg::ets_cfg_s SET_DATA,
   input wire logic SAVE_PARAMETERS,
   input wire logic NV_VALID,
   input wire ets_pkg::ets_cfg_s NV_CFG,
   input wire logic CMD_POS_LOAD,
   input wire logic signed [31:0] COMMANDED_POSITION,
   input wire logic [4:0] UNIT_SHIFT,
   input wire logic HOME_SEEK_POSITIVE,
   input wire logic HOME_SEEK_NEGATIVE,
   input wire logic HOME_USES_TIMING,
   input wire logic ALARM_CLR,
   output ets_pkg::ets_cfg_s CFG_ACTIVE,
   output ets_pkg::ets_cfg_s CFG_PENDING,
   output logic CFG_READY,
   output logic SET_REJECT,
   output logic NV_WR,
   output ets_pkg::ets_cfg_s NV_WR_DATA,
   output logic signed [31:0] ENCODER_COUNT,
   output logic signed [31:0] FEEDBACK_POSITION,
   output logic TIMING_SIGNAL,
   output logic SYSTEM_ALARM
);

   ets_pkg::ets_top_s st_r;
   ets_pkg::ets_top_s st_nxt;
   logic [ets_pkg::SRC_N-1:0] up;
   logic [ets_pkg::SRC_N-1:0] dn;
   logic [ets_pkg::SRC_N-1:0] ph_a;
   logic [ets_pkg::SRC_N-1:0] ph_b;
   logic [ets_pkg::TIN_N-1:0] tin;
   logic sel_up;
   logic sel_dn;
   logic sel_timing;
   logic seek_req;
   logic set_ok;

   // ----------------------------------------------------------------------
   // Phase decoders, one per encoder source
   // ----------------------------------------------------------------------
   assign ph_a[ets_pkg::SRC_DRIVER] = DRV_PHASE_A;
   assign ph_b[ets_pkg::SRC_DRIVER] = DRV_PHASE_B;
   assign ph_a[ets_pkg::SRC_EXTERNAL] = EXT_PHASE_A;
   assign ph_b[ets_pkg::SRC_EXTERNAL] = EXT_PHASE_B;

   generate
      for (genvar g = 0; g < ets_pkg::SRC_N; g++) begin : g_dec
         ets_quad_dec u_dec (
            .clk(MCLK),
            .rst_n(RESET_N),
            .phase_a(ph_a[g]),
            .phase_b(ph_b[g]),
            .step_up(up[g]),
            .step_dn(dn[g])
         );
      end
   endgenerate

   assign tin[ets_pkg::TIN_DIFF] = DRV_DIFF_TIMING_IN;
   assign tin[ets_pkg::TIN_EXTERNAL_ZERO_PULSE] = EXT_ZERO_PULSE;
   assign tin[ets_pkg::TIN_SINGLE] = SINGLE_TIMING_IN;

   // ----------------------------------------------------------------------
   // Selection muxes driven by the active setting only
   // ----------------------------------------------------------------------
   always_comb begin
      sel_up = 1'b0;
      sel_dn = 1'b0;
      unique case (st_r.act.enc)
         ets_pkg::ENC_DRIVER: begin
            sel_up = up[ets_pkg::SRC_DRIVER];
            sel_dn = dn[ets_pkg::SRC_DRIVER];
         end
         ets_pkg::ENC_EXTERNAL: begin
            sel_up = up[ets_pkg::SRC_EXTERNAL];
            sel_dn = dn[ets_pkg::SRC_EXTERNAL];
         end
         default: begin
            sel_up = 1'b0;
            sel_dn = 1'b0;
         end
      endcase
   end

   // Only synchronised zero pulses reach the timing mux
   always_comb begin
      sel_timing = 1'b0;
      if (st_r.act.tim == ets_pkg::TIM_SINGLE) begin
         sel_timing = st_r.t2[ets_pkg::TIN_SINGLE];
      end else if (st_r.act.enc == ets_pkg::ENC_DRIVER) begin
         sel_timing = st_r.t2[ets_pkg::TIN_DIFF];
      end else if (st_r.act.enc == ets_pkg::ENC_EXTERNAL) begin
         sel_timing = st_r.t2[ets_pkg::TIN_EXTERNAL_ZERO_PULSE];
      end
   end

   assign seek_req = (HOME_SEEK_POSITIVE || HOME_SEEK_NEGATIVE) && HOME_USES_TIMING;
   // Value 3 is not a source; a sequence may only read the setting
   assign set_ok = SET_WR && !SET_FROM_SEQ && (SET_DATA.enc != 2'h3);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.nv_wr = 1'b0;
      st_nxt.reject = SET_WR && !set_ok;
      st_nxt.t1 = tin;
      st_nxt.t2 = st_r.t1;
      if (st_r.phase == ets_pkg::ETS_BOOT) begin
         // Stored setting is caught one edge after reset release
         st_nxt.phase = ets_pkg::ETS_RUN;
         if (NV_VALID) begin
            st_nxt.act = NV_CFG;
            st_nxt.pend = NV_CFG;
         end else begin
            st_nxt.act.enc = ets_pkg::ENC_FACTORY;
            st_nxt.act.tim = ets_pkg::TIM_FACTORY;
            st_nxt.pend = st_nxt.act;
         end
      end else begin
         // Writes land in the pending copy; the active copy is frozen until reset
         if (set_ok) begin
            st_nxt.pend = SET_DATA;
         end
         if (SAVE_PARAMETERS) begin
            st_nxt.nv_wr = 1'b1;
            st_nxt.nv_data = set_ok ? SET_DATA : st_r.pend;
         end
      end
      st_nxt.timing = sel_timing;
      if (st_r.act.enc == ets_pkg::ENC_NONE) begin
         st_nxt.count = ets_pkg::POS_RST;
      end else if (CMD_POS_LOAD) begin
         // Needs an encoder source selected: with source 0 the count stays at zero and the command is ignored
         st_nxt.count = COMMANDED_POSITION <<< UNIT_SHIFT;
      end else if (sel_up) begin
         st_nxt.count = st_r.count + 32'sh0000_0001;
      end else if (sel_dn) begin
         st_nxt.count = st_r.count - 32'sh0000_0001;
      end
      st_nxt.fpos = st_r.count >>> UNIT_SHIFT;
      if (ALARM_CLR) begin
         st_nxt.alarm = 1'b0;
      end
      // Alarm set wins over a clear in the same cycle
      if (seek_req && (st_r.phase == ets_pkg::ETS_RUN)
            && (st_r.act.enc == ets_pkg::ENC_NONE)
            && (st_r.act.tim == ets_pkg::TIM_DIFF_OR_ZERO)) begin
         st_nxt.alarm = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         st_r.phase <= ets_pkg::ETS_BOOT;
         st_r.act.enc <= ets_pkg::ENC_FACTORY;
         st_r.act.tim <= ets_pkg::TIM_FACTORY;
         st_r.pend.enc <= ets_pkg::ENC_FACTORY;
         st_r.pend.tim <= ets_pkg::TIM_FACTORY;
         st_r.t1 <= ets_pkg::TSYNC_RST;
         st_r.t2 <= ets_pkg::TSYNC_RST;
         st_r.timing <= 1'b0;
         st_r.count <= ets_pkg::POS_RST;
         st_r.fpos <= ets_pkg::POS_RST;
         st_r.alarm <= 1'b0;
         st_r.nv_wr <= 1'b0;
         st_r.nv_data.enc <= ets_pkg::ENC_FACTORY;
         st_r.nv_data.tim <= ets_pkg::TIM_FACTORY;
         st_r.reject <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign CFG_ACTIVE = st_r.act;
   assign CFG_PENDING = st_r.pend;
   assign CFG_READY = (st_r.phase == ets_pkg::ETS_RUN);
   assign SET_REJECT = st_r.reject;
   assign NV_WR = st_r.nv_wr;
   assign NV_WR_DATA = st_r.nv_data;
   assign ENCODER_COUNT = st_r.count;
   assign FEEDBACK_POSITION = st_r.fpos;
   assign TIMING_SIGNAL = st_r.timing;
   assign SYSTEM_ALARM = st_r.alarm;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   AST_ENC_DECODE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      CFG_READY |-> (CFG_ACTIVE.enc != 2'h3))
      else $error("active encoder source holds an illegal code");

   AST_COUNT_STEP: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_READY && CFG_ACTIVE.enc != ets_pkg::ENC_NONE && !CMD_POS_LOAD && sel_up)
      |=> (ENCODER_COUNT == $past(ENCODER_COUNT) + 32'sh0000_0001))
      else $error("selected encoder step did not advance the count");

   AST_FPOS_SCALE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      $stable(UNIT_SHIFT)
      |=> (FEEDBACK_POSITION == ($past(ENCODER_COUNT) >>> $past(UNIT_SHIFT))))
      else $error("feedback position does not follow the scaled count");

   AST_COUNT_ZERO: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_ACTIVE.enc == ets_pkg::ENC_NONE) [*2] |-> (ENCODER_COUNT == 32'sh0000_0000))
      else $error("count moved while no encoder is selected");

   AST_CMD_LOAD: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CMD_POS_LOAD && CFG_ACTIVE.enc != ets_pkg::ENC_NONE)
      |=> (ENCODER_COUNT == ($past(COMMANDED_POSITION) <<< $past(UNIT_SHIFT))))
      else $error("commanded position not loaded into the count");

   AST_TIM_SINGLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_ACTIVE.tim == ets_pkg::TIM_SINGLE && CFG_READY)
      |=> (TIMING_SIGNAL == $past(st_r.t2[ets_pkg::TIN_SINGLE])))
      else $error("single-ended timing input not routed");

   AST_TIM_ENC: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_ACTIVE.tim == ets_pkg::TIM_DIFF_OR_ZERO && CFG_READY)
      |=> (TIMING_SIGNAL == ($past(CFG_ACTIVE.enc) == ets_pkg::ENC_DRIVER
         ? $past(st_r.t2[ets_pkg::TIN_DIFF])
         : ($past(CFG_ACTIVE.enc) == ets_pkg::ENC_EXTERNAL
            ? $past(st_r.t2[ets_pkg::TIN_EXTERNAL_ZERO_PULSE]) : 1'b0))))
      else $error("timing source does not follow the encoder source");

   AST_ALARM_SET: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (seek_req && CFG_READY && CFG_ACTIVE == '0)
      |=> (SYSTEM_ALARM ##1 (SYSTEM_ALARM || $past(ALARM_CLR))))
      else $error("home seek without timing source did not raise alarm");

   AST_ALARM_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (SYSTEM_ALARM && !ALARM_CLR) |=> SYSTEM_ALARM)
      else $error("alarm dropped without a clear");

   AST_ALARM_CLEAR: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (ALARM_CLR && !seek_req) |=> !SYSTEM_ALARM)
      else $error("alarm clear had no effect");

   AST_TIM_NONE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_READY && CFG_ACTIVE == '0) |=> !TIMING_SIGNAL)
      else $error("timing signal active with no source selected");

   AST_COUNT_DOWN: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_READY && CFG_ACTIVE.enc != ets_pkg::ENC_NONE && !CMD_POS_LOAD && sel_dn && !sel_up)
      |=> (ENCODER_COUNT == $past(ENCODER_COUNT) - 32'sh0000_0001))
      else $error("selected encoder step did not lower the count");

   AST_SET_ACCEPT: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_READY && SET_WR && !SET_FROM_SEQ && SET_DATA.enc != 2'h3)
      |=> (CFG_PENDING == $past(SET_DATA) && !SET_REJECT))
      else $error("immediate write not taken into the pending setting");

   AST_SAVE_PULSE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (SAVE_PARAMETERS && CFG_READY) |=> NV_WR)
      else $error("save did not write the store");

   AST_NV_QUIET: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !SAVE_PARAMETERS |=> !NV_WR)
      else $error("store written without a save");

   AST_READY_RISE: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !$past(RESET_N) |-> (!CFG_READY ##1 CFG_READY))
      else $error("ready did not rise on the second edge after reset");

   AST_ACTIVE_FROZEN: assert property (@(posedge MCLK) disable iff (!RESET_N)
      CFG_READY |=> $stable(CFG_ACTIVE))
      else $error("active setting changed without a reset");

   AST_SEQ_READONLY: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (CFG_READY && SET_WR && SET_FROM_SEQ) |=> ($stable(CFG_PENDING) && SET_REJECT))
      else $error("sequence write changed the setting");

endmodule

/* File: pkg/ets_pkg.sv */
// Package: constants, carriers and state records for encoder and timing source selection
package ets_pkg;

   // ----------------------------------------------------------------------
   // Setting encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] ENC_NONE = 2'h0;
   localparam logic [1:0] ENC_DRIVER = 2'h1;
   localparam logic [1:0] ENC_EXTERNAL = 2'h2;
   localparam logic TIM_DIFF_OR_ZERO = 1'h0;
   localparam logic TIM_SINGLE = 1'h1;

   // ----------------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------------
   localparam logic [1:0] ENC_FACTORY = 2'h0;
   localparam logic TIM_FACTORY = 1'h0;
   localparam int POS_W = 32;
   localparam logic [31:0] POS_RST = 32'h0000_0000;
   localparam logic [1:0] PHASE_RST = 2'h0;
   localparam logic [2:0] TSYNC_RST = 3'h0;

   // ----------------------------------------------------------------------
   // Field positions of the timing input vector
   // ----------------------------------------------------------------------
   localparam int TIN_DIFF = 0;
   localparam int TIN_EXTERNAL_ZERO_PULSE = 1;
   localparam int TIN_SINGLE = 2;
   localparam int TIN_N = 3;

   // ----------------------------------------------------------------------
   // Encoder source index in the decoder array
   // ----------------------------------------------------------------------
   localparam int SRC_DRIVER = 0;
   localparam int SRC_EXTERNAL = 1;
   localparam int SRC_N = 2;

   typedef enum logic {
      ETS_BOOT = 1'b0,
      ETS_RUN = 1'b1
   } ets_phase_e;

   // Stored selection settings travel together
   typedef struct packed {
      logic [1:0] enc;
      logic tim;
   } ets_cfg_s;

   // Quadrature decoder state
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] prev;
   } ets_qd_s;

   // Selector state
   typedef struct packed {
      ets_phase_e phase;
      ets_cfg_s act;
      ets_cfg_s pend;
      logic [TIN_N-1:0] t1;
      logic [TIN_N-1:0] t2;
      logic timing;
      logic signed [POS_W-1:0] count;
      logic signed [POS_W-1:0] fpos;
      logic alarm;
      logic nv_wr;
      ets_cfg_s nv_data;
      logic reject;
   } ets_top_s;

   // Returns {up, down} for one move between two gray phase states
   function automatic logic [1:0] ets_qd_step(input logic [1:0] prev, input logic [1:0] cur);
      logic [3:0] tr;
      tr = {prev, cur};
      unique case (tr)
         4'h1, 4'h7, 4'hE, 4'h8: ets_qd_step = 2'h2;
         4'h2, 4'hB, 4'hD, 4'h4: ets_qd_step = 2'h1;
         default: ets_qd_step = 2'h0;
      endcase
   endfunction

endpackage

/* File: design/ets_quad_dec.sv */
// Quadrature phase synchroniser and step decoder
`timescale 1ns/1ns
module ets_quad_dec (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic phase_a,
   input wire logic phase_b,
   output logic step_up,
   output logic step_dn
);

   ets_pkg::ets_qd_s st_r;
   ets_pkg::ets_qd_s st_nxt;
   logic [1:0] dir;

   // ----------------------------------------------------------------------
   // Two-stage synchroniser, then edge compare on the second stage only
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {phase_a, phase_b};
      st_nxt.s2 = st_r.s1;
      st_nxt.prev = st_r.s2;
   end

   // Keeps sampling through reset: clearing it would fake a step when a pin rests high
   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   // A double-step (both phases flip) is dropped rather than guessed
   assign dir = rst_n ? ets_pkg::ets_qd_step(st_r.prev, st_r.s2) : 2'h0;
   assign step_up = dir[1];
   assign step_dn = dir[0];

endmodule

/* File: tb/ets_enc_model.sv */
// Quadrature encoder model moved one step per request
`timescale 1ns/1ns
module ets_enc_model (
   input wire logic clk,
   input wire logic step,
   input wire logic up,
   output logic a,
   output logic b
);
   logic [1:0] idx = 2'h0;
   logic pend = 1'b0;
   logic dir = 1'b0;
   always @(posedge clk) begin
      pend <= step;
      dir <= up;
   end
   // Pins move on the falling edge, far from the sampling edge of the selector
   always @(negedge clk) begin
      if (pend) begin
         idx <= dir ? idx + 2'h1 : idx - 2'h1;
      end
   end
   // Gray order 00,01,11,10 going up: B leads
   assign a = idx[1];
   assign b = idx[1] ^ idx[0];
endmodule

/* File: tb/tb_ets_source_select.sv */
// Self-checking bench for the encoder and timing source selector
`timescale 1ns/1ns
module tb_ets_source_select;
   typedef struct packed {logic [3:0] sel; logic [31:0] v;} ets_note_s;
   logic MCLK = 1'b0;
   logic RESET_N = 1'b0;
   logic dstep = 1'b0, dup = 1'b0, estep = 1'b0, eup = 1'b0;
   wire logic drv_a, drv_b, ext_a, ext_b;
   logic diff_in = 1'b0, external_zero_pulse = 1'b0, single_in = 1'b0;
   logic set_wr = 1'b0, set_seq = 1'b0, save = 1'b0, nv_valid = 1'b0;
   ets_pkg::ets_cfg_s set_data = 3'h0;
   ets_pkg::ets_cfg_s nv_cfg = 3'h0;
   logic pos_load = 1'b0, hsp = 1'b0, hsn = 1'b0, huses = 1'b0, aclr = 1'b0;
   logic signed [31:0] cmd_pos = 32'h0;
   logic [4:0] shift = 5'h0;
   ets_pkg::ets_cfg_s cfg_act, cfg_pend, nv_data;
   logic ready, rej, nv_wr, tsig, alarm;
   logic signed [31:0] cnt, fpos, ecnt;
   ets_pkg::ets_cfg_s tbl [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1};
   ets_note_s notes [$];
   ets_note_s cur;
   int n_checks = 0;
   int miscompares = 0;
   int cyc = 0;
   event smp;

   ets_enc_model drv_enc (.clk(MCLK), .step(dstep), .up(dup), .a(drv_a), .b(drv_b));
   ets_enc_model ext_enc (.clk(MCLK), .step(estep), .up(eup), .a(ext_a), .b(ext_b));
   ets_source_select DUT (
      .MCLK(MCLK), .RESET_N(RESET_N), .DRV_PHASE_A(drv_a), .DRV_PHASE_B(drv_b),
      .EXT_PHASE_A(ext_a), .EXT_PHASE_B(ext_b), .DRV_DIFF_TIMING_IN(diff_in),
      .EXT_ZERO_PULSE(external_zero_pulse), .SINGLE_TIMING_IN(single_in), .SET_WR(set_wr),
      .SET_FROM_SEQ(set_seq), .SET_DATA(set_data), .SAVE_PARAMETERS(save),
      .NV_VALID(nv_valid), .NV_CFG(nv_cfg), .CMD_POS_LOAD(pos_load),
      .COMMANDED_POSITION(cmd_pos), .UNIT_SHIFT(shift), .HOME_SEEK_POSITIVE(hsp),
      .HOME_SEEK_NEGATIVE(hsn), .HOME_USES_TIMING(huses), .ALARM_CLR(aclr),
      .CFG_ACTIVE(cfg_act), .CFG_PENDING(cfg_pend), .CFG_READY(ready), .SET_REJECT(rej),
      .NV_WR(nv_wr), .NV_WR_DATA(nv_data), .ENCODER_COUNT(cnt), .FEEDBACK_POSITION(fpos),
      .TIMING_SIGNAL(tsig), .SYSTEM_ALARM(alarm));

   // ----------------------------------------------------------------------
   // Clock, timeout, verdict
   // ----------------------------------------------------------------------
   initial forever #20 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Expectation queue and comparison
   // ----------------------------------------------------------------------
   task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", nm, e, s);
      end
   endtask
   initial forever begin
      @(smp);
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         case (cur.sel)
            4'h0: cmp_word("count", cur.v, cnt);
            4'h1: cmp_word("feedback", cur.v, fpos);
            4'h2: cmp_bit("timing", cur.v[0], tsig);
            4'h3: cmp_bit("alarm", cur.v[0], alarm);
            4'h4: cmp_word("pending", cur.v, {29'h0, cfg_pend});
            4'h5: cmp_word("active", cur.v, {29'h0, cfg_act});
            4'h6: cmp_bit("reject", cur.v[0], rej);
            4'h7: cmp_bit("nv_write", cur.v[0], nv_wr);
            4'h8: cmp_word("nv_data", cur.v, {29'h0, nv_data});
            default: cmp_bit("ready", cur.v[0], ready);
         endcase
      end
   end
   task automatic note(input logic [3:0] sel, input logic [31:0] v);
      notes.push_back({sel, v});
   endtask
   task automatic fire();
      -> smp;
      #1;
   endtask
   task automatic wn(input int n);
      repeat (n) @(negedge MCLK);
   endtask

   // ----------------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------------
   task automatic do_reset(input logic v, input ets_pkg::ets_cfg_s c);
      RESET_N = 1'b0;
      nv_valid = v;
      nv_cfg = c;
      wn(8);
      RESET_N = 1'b1;
      wn(2);
      note(4'h5, v ? {29'h0, c} : 32'h0);
      note(4'h9, 32'h1);
      note(4'h0, 32'h0);
      fire();
   endtask
   task automatic set(input ets_pkg::ets_cfg_s d, input logic s);
      set_data = d;
      set_seq = s;
      set_wr = 1'b1;
      wn(1);
      set_wr = 1'b0;
      set_seq = 1'b0;
   endtask
   task automatic steps(input ets_pkg::ets_cfg_s c, input int n);
      logic u;
      logic e;
      for (int i = 0; i < n; i++) begin
         u = 1'($urandom_range(1, 0));
         e = 1'($urandom_range(1, 0));
         dup = u;
         eup = u;
         dstep = e;
         estep = !e;
         wn(1);
         dstep = 1'b0;
         estep = 1'b0;
         wn(1);
         if ((e && c.enc == ets_pkg::ENC_DRIVER) || (!e && c.enc == ets_pkg::ENC_EXTERNAL)) begin
            ecnt = u ? ecnt + 1 : ecnt - 1;
         end
      end
      wn(6);
      note(4'h0, ecnt);
      note(4'h1, ecnt >>> shift);
      fire();
   endtask
   task automatic timing(input ets_pkg::ets_cfg_s c);
      logic x;
      for (int k = 0; k < 3; k++) begin
         {single_in, external_zero_pulse, diff_in} = 3'h1 << k;
         wn(5);
         x = c.tim ? k == 2 : (c.enc == ets_pkg::ENC_DRIVER && k == 0)
            || (c.enc == ets_pkg::ENC_EXTERNAL && k == 1);
         note(4'h2, {31'h0, x});
         fire();
      end
      {single_in, external_zero_pulse, diff_in} = 3'h0;
   endtask
   task automatic seek(input ets_pkg::ets_cfg_s c);
      for (int d = 0; d < 3; d++) begin
         huses = d < 2;
         hsp = d == 0;
         hsn = d != 0;
         wn(1);
         {hsp, hsn} = 2'h0;
         note(4'h3, d < 2 && c == 3'h0);
         fire();
         aclr = 1'b1;
         wn(1);
         aclr = 1'b0;
         note(4'h3, 32'h0);
         fire();
      end
   endtask

   initial begin
      void'($urandom(32'hE1F6));
      do_reset(1'b0, 3'h0);
      // Immediate write lands in pending only; the active choice waits for reset
      set(3'h2, 1'b0);
      note(4'h6, 32'h0);
      note(4'h4, 32'h2);
      note(4'h5, 32'h0);
      fire();
      set(3'h5, 1'b1);
      note(4'h6, 32'h1);
      note(4'h4, 32'h2);
      fire();
      set(3'h6, 1'b0);
      note(4'h6, 32'h1);
      note(4'h4, 32'h2);
      fire();
      save = 1'b1;
      wn(1);
      save = 1'b0;
      note(4'h7, 32'h1);
      note(4'h8, 32'h2);
      fire();
      wn(1);
      note(4'h7, 32'h0);
      fire();
      // A write taken in the same cycle as the save is what gets stored
      save = 1'b1;
      set(3'h4, 1'b0);
      save = 1'b0;
      note(4'h7, 32'h1);
      note(4'h8, 32'h4);
      note(4'h4, 32'h4);
      fire();
      for (int i = 0; i < 5; i++) begin
         do_reset(1'b1, tbl[i]);
         shift = 5'($urandom_range(3, 0));
         ecnt = 0;
         steps(tbl[i], 12);
         cmd_pos = 32'($urandom_range(50, 0)) - 32'sd25;
         pos_load = 1'b1;
         wn(1);
         pos_load = 1'b0;
         wn(3);
         ecnt = (tbl[i].enc != ets_pkg::ENC_NONE) ? cmd_pos <<< shift : 32'sh0;
         note(4'h0, ecnt);
         note(4'h1, ecnt >>> shift);
         fire();
         steps(tbl[i], 8);
         timing(tbl[i]);
         seek(tbl[i]);
      end
      print_verdict();
   end
endmodule
